/* File: logic/board_reset_seq.sv */
`timescale 1ns/1ps
// Functional notes
// - Power-on reset is the AND of all its active-low sources.
// - Power-manager reset output low asserts power-on reset.
// - Low 1.2V power-good asserts power-on reset.
// - Pressed power-on button asserts power-on reset.
// - Harness power-on request low pulls power-on reset low while held.
// - Open-drain copy of power-on reset drives the flash reset.
// - Power-on reset gates boot buffer enable and resets PHY, add-on, edge.
// - Pressed warm button asserts the warm reset.
// - Harness warm request low pulls the warm net low while held.
// - Warm net is wired and fans out to expander, SD and edge.
// - Pressed interrupt button asserts the external interrupt.
// - Harness interrupt request low pulls the interrupt low while held.
// - Boot code comes from DIP switch or harness expander.
// - Decode the 4-bit boot code; unknown codes are unsupported.
// - Quad flash boot uses four single-rate lanes at 50MHz.
// - Flash load failure in quad, single or octal falls back to UART.
// - UART boot runs the first UART at 115200bps with x-modem.
// - xSPI boot starts single-lane 25MHz, then eight-lane double-rate.
// - Development boot runs with no secondary loader.
// - Processor gets a 25MHz reference clock.
// - A switch selects the JTAG path for the processor.
module board_reset_seq
	import board_reset_pkg::*;
(
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Reset sources
	input wire logic pwrmgr_rst_out_n,
	input wire logic pg_1v2,
	input wire logic poweron_button_n,
	input wire logic harness_por_req_n,
	input wire logic button_warm_rst_n,
	input wire logic harness_warm_req_n,
	input wire logic main_warm_rst_n_i,
	input wire logic irq_button_n,
	input wire logic harness_irq_req_n,
	// Boot code and JTAG sources
	input wire logic [3:0] boot_dip_switch,
	input wire logic [3:0] harness_boot_code,
	input wire logic harness_boot_drive_n,
	input wire logic jtag_path_switch,
	// Power-on reset fan-out
	output logic main_poweron_rst_n,
	output logic flash_rst_n_o,
	output logic flash_rst_n_oe,
	output logic phy_rst_n,
	output logic addon_eth_rst_n,
	output logic edge_por_rst_n,
	output logic boot_buf_oe_n,
	// Warm reset net and fan-out
	output logic main_warm_rst_n_o,
	output logic main_warm_rst_n_oe,
	output logic ioexp_rst_n,
	output logic sd_rst_n,
	output logic edge_warm_rst_n,
	// Interrupt, clock, JTAG
	output logic ext_irq_n,
	output logic ref_clock_input,
	output logic jtag_sel,
	// Boot behaviour
	output boot_mode_type boot_mode,
	output logic [3:0] boot_code,
	output logic [3:0] flash_lanes,
	output logic flash_ddr,
	output logic [7:0] flash_clk_mhz,
	output logic secondary_loader
);

	// ****************************************************************
	// Input synchronisation
	// ****************************************************************
	logic [SYNC_W-1:0] pins;
	logic [SYNC_W-1:0] lvl;

	assign pins = {harness_boot_code, boot_dip_switch, jtag_path_switch,
		harness_boot_drive_n, harness_irq_req_n, irq_button_n,
		main_warm_rst_n_i, harness_warm_req_n, button_warm_rst_n,
		harness_por_req_n, poweron_button_n, pg_1v2, pwrmgr_rst_out_n};

	pin_sync3 #(
		.WIDTH(SYNC_W),
		.RST_VAL(SYNC_RST)
	) u_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.d(pins),
		.q(lvl)
	);

	// ****************************************************************
	// Power-on reset
	// ****************************************************************
	logic por_n_d;
	logic por_n_q;

	// Harness request is one more AND term, the pull to ground.
	assign por_n_d = lvl[SRC_PWRMGR] & lvl[SRC_PG1V2] & lvl[SRC_POR_BTN]
		& lvl[SRC_HAR_POR];

	// Assertion through hresetn is asynchronous; release waits for filtering.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			por_n_q <= 1'b0;
			main_poweron_rst_n <= 1'b0;
			flash_rst_n_oe <= 1'b1;
			phy_rst_n <= 1'b0;
			addon_eth_rst_n <= 1'b0;
			edge_por_rst_n <= 1'b0;
			boot_buf_oe_n <= 1'b0;
		end
		else
		begin
			por_n_q <= por_n_d;
			main_poweron_rst_n <= por_n_d;
			flash_rst_n_oe <= !por_n_d;
			phy_rst_n <= por_n_d;
			addon_eth_rst_n <= por_n_d;
			edge_por_rst_n <= por_n_d;
			boot_buf_oe_n <= por_n_d;
		end
	end

	// ****************************************************************
	// Warm reset net and external interrupt
	// ****************************************************************
	// The net also carries the processor's own warm output, so fan-out
	// follows the sensed net level, not just our own pull.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			flash_rst_n_o <= 1'b0;
			main_warm_rst_n_o <= 1'b0;
			main_warm_rst_n_oe <= 1'b1;
			ioexp_rst_n <= 1'b0;
			sd_rst_n <= 1'b0;
			edge_warm_rst_n <= 1'b0;
			ext_irq_n <= 1'b1;
			jtag_sel <= 1'b0;
		end
		else
		begin
			flash_rst_n_o <= 1'b0;
			main_warm_rst_n_o <= 1'b0;
			main_warm_rst_n_oe <= !(lvl[SRC_WARM_BTN] & lvl[SRC_HAR_WARM]);
			ioexp_rst_n <= lvl[SRC_WARM_NET];
			sd_rst_n <= lvl[SRC_WARM_NET];
			edge_warm_rst_n <= lvl[SRC_WARM_NET];
			ext_irq_n <= lvl[SRC_IRQ_BTN] & lvl[SRC_HAR_IRQ];
			jtag_sel <= lvl[SRC_JTAG];
		end
	end

	// ****************************************************************
	// Reference clock
	// ****************************************************************
	logic [2:0] ref_cnt_q;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			ref_cnt_q <= 3'h0;
			ref_clock_input <= 1'b0;
		end
		else if (ref_cnt_q == REF_HALF_LAST)
		begin
			ref_cnt_q <= 3'h0;
			ref_clock_input <= !ref_clock_input;
		end
		else
			ref_cnt_q <= ref_cnt_q + 3'h1;
	end

	// ****************************************************************
	// Boot code capture and decode
	// ****************************************************************
	function automatic boot_mode_type decode_boot(input logic [3:0] code);
		case (code)
			CODE_QUAD: decode_boot = BOOT_QUAD;
			CODE_UART: decode_boot = BOOT_UART;
			CODE_SINGLE: decode_boot = BOOT_SINGLE;
			CODE_OCTAL: decode_boot = BOOT_OCTAL;
			CODE_XSPI: decode_boot = BOOT_XSPI;
			CODE_DEV: decode_boot = BOOT_DEV;
			default: decode_boot = BOOT_UNSUP;
		endcase
	endfunction : decode_boot

	logic [3:0] code_live;
	logic fallback_q;
	logic sfdp_done_q;
	boot_mode_type mode_d;

	assign code_live = !lvl[SRC_HAR_BOOT] ? lvl[SRC_HCODE +: CODE_W]
		: lvl[SRC_DIP +: CODE_W];

	// Latched on the release edge only; a glitching switch later has no effect.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			boot_code <= 4'h0;
		else if (!por_n_q && por_n_d)
			boot_code <= code_live;
	end

	always_comb
	begin
		mode_d = decode_boot(boot_code);
		if (fallback_q && (mode_d == BOOT_QUAD || mode_d == BOOT_SINGLE
			|| mode_d == BOOT_OCTAL))
			mode_d = BOOT_UART;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			boot_mode <= BOOT_UNSUP;
			flash_lanes <= 4'h0;
			flash_ddr <= 1'b0;
			flash_clk_mhz <= 8'h00;
			secondary_loader <= 1'b0;
		end
		else
		begin
			boot_mode <= mode_d;
			secondary_loader <= (mode_d != BOOT_DEV) && (mode_d != BOOT_UNSUP);
			flash_ddr <= 1'b0;
			case (mode_d)
				BOOT_QUAD:
				begin
					flash_lanes <= LANES_4;
					flash_clk_mhz <= FLASH_MHZ;
				end
				BOOT_SINGLE:
				begin
					flash_lanes <= LANES_1;
					flash_clk_mhz <= FLASH_MHZ;
				end
				BOOT_OCTAL:
				begin
					flash_lanes <= LANES_8;
					flash_clk_mhz <= FLASH_MHZ;
				end
				BOOT_XSPI:
				begin
					flash_lanes <= sfdp_done_q ? LANES_8 : LANES_1;
					flash_ddr <= sfdp_done_q;
					flash_clk_mhz <= XSPI_START_MHZ;
				end
				default:
				begin
					flash_lanes <= 4'h0;
					flash_clk_mhz <= 8'h00;
				end
			endcase
		end
	end

	// ****************************************************************
	// AHB-Lite slave
	// ****************************************************************
	logic take;
	logic wr_pend_q;
	logic [ADDR_W-1:0] wr_addr_q;
	logic wr_ctrl;

	assign take = hsel && htrans[1] && hready;
	assign wr_ctrl = wr_pend_q && (wr_addr_q == OFS_CTRL);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= '0;
			hrdata <= 32'h0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			wr_pend_q <= take && hwrite && (haddr[31:ADDR_W] == '0);
			wr_addr_q <= haddr[ADDR_W-1:0];
			hrdata <= 32'h0;
			if (take && !hwrite && haddr[31:ADDR_W] == '0)
				case (haddr[ADDR_W-1:0])
					OFS_STATUS: hrdata <= {12'h000, lvl, main_poweron_rst_n};
					OFS_BOOT: hrdata <= {17'h0, secondary_loader, fallback_q,
						flash_ddr, flash_lanes, 1'b0, boot_mode, boot_code};
					OFS_CTRL: hrdata <= {30'h0, sfdp_done_q, fallback_q};
					OFS_FLASH_CLK: hrdata <= {24'h000000, flash_clk_mhz};
					OFS_UART_BAUD: hrdata <= UART_BAUD;
					default: hrdata <= 32'h0;
				endcase
		end
	end

	// Software reports a load failure or SFDP completion; a new power-on
	// clears both, but a report in the same cycle wins.
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			fallback_q <= 1'b0;
			sfdp_done_q <= 1'b0;
		end
		else
		begin
			if (wr_ctrl && hwdata[CTRL_LOAD_FAIL])
				fallback_q <= 1'b1;
			else if (!por_n_q)
				fallback_q <= 1'b0;
			if (wr_ctrl && hwdata[CTRL_SFDP_DONE])
				sfdp_done_q <= 1'b1;
			else if (!por_n_q)
				sfdp_done_q <= 1'b0;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_por_and_sources: assert property (
		(&{lvl[SRC_PWRMGR], lvl[SRC_PG1V2], lvl[SRC_POR_BTN], lvl[SRC_HAR_POR]})
		|=> main_poweron_rst_n) else $error("por not released with all sources high");
	a_por_pwrmgr: assert property (
		!lvl[SRC_PWRMGR] |=> !main_poweron_rst_n) else $error("pwrmgr did not assert por");
	a_por_pgood: assert property (
		!lvl[SRC_PG1V2] |=> !main_poweron_rst_n) else $error("power-good did not assert por");
	a_por_button: assert property (
		!lvl[SRC_POR_BTN] |=> !main_poweron_rst_n) else $error("button did not assert por");
	a_por_harness: assert property (
		!lvl[SRC_HAR_POR] [*2] |-> !main_poweron_rst_n [*2])
		else $error("harness por request not held");
	a_flash_od: assert property (
		flash_rst_n_oe == !main_poweron_rst_n && !flash_rst_n_o)
		else $error("flash open-drain reset mismatch");
	a_por_fanout: assert property (
		!main_poweron_rst_n |-> !phy_rst_n && !addon_eth_rst_n && !edge_por_rst_n
		&& !boot_buf_oe_n) else $error("por fan-out mismatch");
	a_warm_pull: assert property (
		!lvl[SRC_WARM_BTN] |=> main_warm_rst_n_oe) else $error("warm button not pulled");
	a_warm_harness: assert property (
		$fell(lvl[SRC_HAR_WARM]) |=> main_warm_rst_n_oe && !main_warm_rst_n_o)
		else $error("harness warm request not pulled");
	a_warm_fanout: assert property (
		!lvl[SRC_WARM_NET] |=> !ioexp_rst_n && !sd_rst_n && !edge_warm_rst_n)
		else $error("warm fan-out mismatch");
	a_irq_button: assert property (
		!lvl[SRC_IRQ_BTN] |=> !ext_irq_n) else $error("irq button ignored");
	a_irq_harness: assert property (
		!lvl[SRC_HAR_IRQ] |=> !ext_irq_n) else $error("harness irq ignored");
	a_code_decode: assert property (
		boot_code == CODE_DEV |=> boot_mode == BOOT_DEV && !secondary_loader)
		else $error("development code misdecoded");
	a_quad_lanes: assert property (
		boot_mode == BOOT_QUAD |-> flash_lanes == LANES_4 && flash_clk_mhz == FLASH_MHZ
		&& !flash_ddr) else $error("quad flash setup wrong");
	a_fallback_uart: assert property (
		fallback_q && decode_boot(boot_code) == BOOT_OCTAL |=> boot_mode == BOOT_UART)
		else $error("no uart fallback");
	a_xspi_switch: assert property (
		boot_mode == BOOT_XSPI && !sfdp_done_q ##1 boot_mode == BOOT_XSPI
		|-> flash_lanes == LANES_1 && !flash_ddr) else $error("xspi start wrong");
	a_code_hold: assert property (
		por_n_q && $past(por_n_q) |-> $stable(boot_code)) else $error("boot code moved");
	a_ref_clock: assert property (
		$rose(ref_clock_input) |-> ##4 $fell(ref_clock_input)) else $error("ref clock period");
	a_jtag_sel: assert property (
		$stable(lvl[SRC_JTAG]) [*2] |-> jtag_sel == lvl[SRC_JTAG])
		else $error("jtag select lags");

	c_por_cycle: cover property ($fell(main_poweron_rst_n) ##[1:200] $rose(main_poweron_rst_n));
	c_warm_pull: cover property ($rose(main_warm_rst_n_oe));
	c_fallback: cover property ($rose(fallback_q) ##1 boot_mode == BOOT_UART);
	c_xspi_ddr: cover property (boot_mode == BOOT_XSPI && flash_ddr);

endmodule : board_reset_seq

/* File: logic/board_reset_pkg.sv */
package board_reset_pkg;

	// ****************************************************************
	// Clocking
	// ****************************************************************
	localparam int CLK_MHZ = 200;
	localparam int REF_MHZ = 25;
	localparam int REF_HALF_INT = CLK_MHZ / (2 * REF_MHZ);
	localparam logic [2:0] REF_HALF_LAST = 3'(REF_HALF_INT - 1);

	// ****************************************************************
	// Synchroniser bit positions
	// ****************************************************************
	localparam int SRC_PWRMGR = 0;
	localparam int SRC_PG1V2 = 1;
	localparam int SRC_POR_BTN = 2;
	localparam int SRC_HAR_POR = 3;
	localparam int SRC_WARM_BTN = 4;
	localparam int SRC_HAR_WARM = 5;
	localparam int SRC_WARM_NET = 6;
	localparam int SRC_IRQ_BTN = 7;
	localparam int SRC_HAR_IRQ = 8;
	localparam int SRC_HAR_BOOT = 9;
	localparam int SRC_JTAG = 10;
	localparam int SRC_DIP = 11;
	localparam int SRC_HCODE = 15;
	localparam int CODE_W = 4;
	localparam int SYNC_W = 19;
	localparam logic [SYNC_W-1:0] SYNC_RST = 19'h380;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int ADDR_W = 5;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h00;
	localparam logic [ADDR_W-1:0] OFS_BOOT = 5'h04;
	localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h08;
	localparam logic [ADDR_W-1:0] OFS_FLASH_CLK = 5'h0C;
	localparam logic [ADDR_W-1:0] OFS_UART_BAUD = 5'h10;
	localparam int CTRL_LOAD_FAIL = 0;
	localparam int CTRL_SFDP_DONE = 1;
	localparam int BOOT_MODE_LSB = 4;
	localparam int BOOT_LANES_LSB = 8;
	localparam int BOOT_DDR = 12;
	localparam int BOOT_FALLBACK = 13;
	localparam int BOOT_LOADER = 14;

	// ****************************************************************
	// Boot codes and behaviours
	// ****************************************************************
	localparam logic [3:0] CODE_QUAD = 4'h0;
	localparam logic [3:0] CODE_UART = 4'h1;
	localparam logic [3:0] CODE_SINGLE = 4'h2;
	localparam logic [3:0] CODE_OCTAL = 4'h3;
	localparam logic [3:0] CODE_XSPI = 4'hC;
	localparam logic [3:0] CODE_DEV = 4'hB;
	localparam logic [7:0] FLASH_MHZ = 8'h32;
	localparam logic [7:0] XSPI_START_MHZ = 8'h19;
	localparam logic [31:0] UART_BAUD = 32'h0001C200;
	localparam logic [3:0] LANES_1 = 4'h1;
	localparam logic [3:0] LANES_4 = 4'h4;
	localparam logic [3:0] LANES_8 = 4'h8;

	typedef enum logic [2:0] {
		BOOT_QUAD,
		BOOT_UART,
		BOOT_SINGLE,
		BOOT_OCTAL,
		BOOT_XSPI,
		BOOT_DEV,
		BOOT_UNSUP
	} boot_mode_type;

endpackage : board_reset_pkg

/* File: logic/pin_sync3.sv */
`timescale 1ns/1ps
module pin_sync3
	import board_reset_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Pins and filtered levels
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] s1_q;
	logic [WIDTH-1:0] s2_q;
	logic [WIDTH-1:0] s3_q;

	// A level is accepted only once two late stages agree, so a runt is dropped.
	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		always_ff @(posedge clk or negedge rst_n)
		begin
			if (!rst_n)
			begin
				s1_q[i] <= RST_VAL[i];
				s2_q[i] <= RST_VAL[i];
				s3_q[i] <= RST_VAL[i];
				q[i] <= RST_VAL[i];
			end
			else
			begin
				s1_q[i] <= d[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (s2_q[i] == s3_q[i])
					q[i] <= s3_q[i];
			end
		end
	end

endmodule : pin_sync3

/* File: dv/src_partner.sv */
`timescale 1ns/1ps
// ****************************************************************
// Board-side model: power manager, buttons, processor, harness
// ****************************************************************
module src_partner
(
	// Clock
	input wire logic hclk,
	// Bench requests, one bit per source, high means asserted
	input wire logic [8:0] act,
	input wire logic [3:0] dip_code,
	input wire logic [3:0] har_code,
	input wire logic har_drive,
	input wire logic jtag_sw,
	// Block side of the wired warm net
	input wire logic warm_o,
	input wire logic warm_oe,
	// Pins toward the block
	output logic pwrmgr_rst_out_n,
	output logic pg_1v2,
	output logic poweron_button_n,
	output logic harness_por_req_n,
	output logic button_warm_rst_n,
	output logic harness_warm_req_n,
	output logic warm_net_n,
	output logic irq_button_n,
	output logic harness_irq_req_n,
	output logic [3:0] boot_dip_switch,
	output logic [3:0] harness_boot_code,
	output logic harness_boot_drive_n,
	output logic jtag_path_switch
);
	logic [8:0] lvl_q = 9'h1FF;
	logic [3:0] dip_q = 4'h0;
	logic [3:0] code_q = 4'h0;
	logic drv_q = 1'b0;
	logic jtag_q = 1'b0;

	// Levels move just after a rising edge, never on the sampling instant.
	always @(posedge hclk)
	begin
		lvl_q <= ~act;
		dip_q <= dip_code;
		jtag_q <= jtag_sw;
		drv_q <= har_drive;
		// A released expander line keeps no value, so it toggles every cycle.
		code_q <= har_drive ? har_code : ~code_q;
	end

	assign pwrmgr_rst_out_n = lvl_q[0];
	assign pg_1v2 = lvl_q[1];
	assign poweron_button_n = lvl_q[2];
	assign harness_por_req_n = lvl_q[3];
	assign button_warm_rst_n = lvl_q[4];
	assign harness_warm_req_n = lvl_q[5];
	// The processor output and the block's pull-down share one net.
	assign warm_net_n = ~((warm_oe & ~warm_o) | ~lvl_q[6]);
	assign irq_button_n = lvl_q[7];
	assign harness_irq_req_n = lvl_q[8];
	assign boot_dip_switch = dip_q;
	assign harness_boot_code = code_q;
	assign harness_boot_drive_n = ~drv_q;
	assign jtag_path_switch = jtag_q;
endmodule : src_partner

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top
	import board_reset_pkg::*;
;
	// ****************************************************************
	// Signals
	// ****************************************************************
	logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, rd_s;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hreadyout, hresp, rdy_s;
	logic [8:0] act = 9'h000;
	logic [3:0] dip_code = 4'h0, har_code = 4'h0, boot_dip_switch, harness_boot_code;
	logic har_drive = 1'b0, jtag_sw = 1'b0;
	logic pwrmgr_rst_out_n, pg_1v2, poweron_button_n, harness_por_req_n, button_warm_rst_n;
	logic harness_warm_req_n, warm_net_n, irq_button_n, harness_irq_req_n;
	logic harness_boot_drive_n, jtag_path_switch, main_poweron_rst_n, flash_rst_n_o;
	logic flash_rst_n_oe, phy_rst_n, addon_eth_rst_n, edge_por_rst_n, boot_buf_oe_n;
	logic main_warm_rst_n_o, main_warm_rst_n_oe, ioexp_rst_n, sd_rst_n, edge_warm_rst_n;
	logic ext_irq_n, ref_clock_input, jtag_sel, flash_ddr, secondary_loader;
	boot_mode_type boot_mode;
	logic [3:0] boot_code, flash_lanes;
	logic [7:0] flash_clk_mhz;
	int cyc = 0, n = 0, failures = 0, num_checks = 0;
	logic [3:0] ctab [7] = '{CODE_QUAD, CODE_UART, CODE_SINGLE, CODE_OCTAL, CODE_XSPI, CODE_DEV, 4'h5};
	boot_mode_type mtab [7] = '{BOOT_QUAD, BOOT_UART, BOOT_SINGLE, BOOT_OCTAL, BOOT_XSPI,
		BOOT_DEV, BOOT_UNSUP};
	logic [3:0] ltab [7] = '{LANES_4, 4'h0, LANES_1, LANES_8, LANES_1, 4'h0, 4'h0};
	logic [7:0] ftab [7] = '{FLASH_MHZ, 8'h0, FLASH_MHZ, FLASH_MHZ, XSPI_START_MHZ, 8'h0, 8'h0};

	board_reset_seq DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.pwrmgr_rst_out_n(pwrmgr_rst_out_n), .pg_1v2(pg_1v2), .poweron_button_n(poweron_button_n),
		.harness_por_req_n(harness_por_req_n), .button_warm_rst_n(button_warm_rst_n),
		.harness_warm_req_n(harness_warm_req_n), .main_warm_rst_n_i(warm_net_n),
		.irq_button_n(irq_button_n), .harness_irq_req_n(harness_irq_req_n),
		.boot_dip_switch(boot_dip_switch), .harness_boot_code(harness_boot_code),
		.harness_boot_drive_n(harness_boot_drive_n), .jtag_path_switch(jtag_path_switch),
		.main_poweron_rst_n(main_poweron_rst_n), .flash_rst_n_o(flash_rst_n_o),
		.flash_rst_n_oe(flash_rst_n_oe), .phy_rst_n(phy_rst_n), .addon_eth_rst_n(addon_eth_rst_n),
		.edge_por_rst_n(edge_por_rst_n), .boot_buf_oe_n(boot_buf_oe_n),
		.main_warm_rst_n_o(main_warm_rst_n_o), .main_warm_rst_n_oe(main_warm_rst_n_oe),
		.ioexp_rst_n(ioexp_rst_n), .sd_rst_n(sd_rst_n), .edge_warm_rst_n(edge_warm_rst_n),
		.ext_irq_n(ext_irq_n), .ref_clock_input(ref_clock_input), .jtag_sel(jtag_sel),
		.boot_mode(boot_mode), .boot_code(boot_code), .flash_lanes(flash_lanes),
		.flash_ddr(flash_ddr), .flash_clk_mhz(flash_clk_mhz), .secondary_loader(secondary_loader));

	src_partner partner (.hclk(hclk), .act(act), .dip_code(dip_code), .har_code(har_code),
		.har_drive(har_drive), .jtag_sw(jtag_sw), .warm_o(main_warm_rst_n_o),
		.warm_oe(main_warm_rst_n_oe), .pwrmgr_rst_out_n(pwrmgr_rst_out_n), .pg_1v2(pg_1v2),
		.poweron_button_n(poweron_button_n), .harness_por_req_n(harness_por_req_n),
		.button_warm_rst_n(button_warm_rst_n), .harness_warm_req_n(harness_warm_req_n),
		.warm_net_n(warm_net_n), .irq_button_n(irq_button_n),
		.harness_irq_req_n(harness_irq_req_n), .boot_dip_switch(boot_dip_switch),
		.harness_boot_code(harness_boot_code), .harness_boot_drive_n(harness_boot_drive_n),
		.jtag_path_switch(jtag_path_switch));

	// ****************************************************************
	// Clock, edge-safe sampling and timeout
	// ****************************************************************
	initial
	begin
		forever #2.5 hclk = ~hclk;
	end

	// Bus answers are copied half a cycle early so the edge never races the flops.
	always @(negedge hclk)
	begin
		rdy_s = hreadyout;
		rd_s = hrdata;
	end

	always @(posedge hclk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			failures++;
			close_out();
		end
	end

	// ****************************************************************
	// Tasks
	// ****************************************************************
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wait_cyc(input int k);
		repeat (k) @(negedge hclk);
	endtask : wait_cyc

	task automatic set_act(input logic [8:0] m);
		@(posedge hclk);
		act <= m;
		wait_cyc(14);
	endtask : set_act

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= wr;
		do @(posedge hclk); while (rdy_s !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (rdy_s !== 1'b1);
		rd = rd_s;
	endtask : ahb

	task automatic wait_ref(input logic v);
		do
		begin
			@(negedge hclk);
			n++;
		end
		while (ref_clock_input !== v && n < 100);
	endtask : wait_ref

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	// ****************************************************************
	// Tests
	// ****************************************************************
	initial
	begin
		repeat (6) @(posedge hclk);
		chk("reset_por", 0, main_poweron_rst_n);
		hresetn <= 1'b1;
		wait_cyc(12);
		for (int i = 0; i < 9; i++)
		begin
			set_act(9'(1 << i));
			chk("por", i > 3, main_poweron_rst_n);
			chk("flash", {i < 4, 1'b0}, {flash_rst_n_oe, flash_rst_n_o});
			chk("por_fan", (i > 3) ? 4'hF : 4'h0, {phy_rst_n, addon_eth_rst_n, edge_por_rst_n,
				boot_buf_oe_n});
			if (i > 3)
			begin
				chk("warm_oe", i == 4 || i == 5, main_warm_rst_n_oe);
				chk("warm_fan", (i < 7) ? 3'h0 : 3'h7, {ioexp_rst_n, sd_rst_n, edge_warm_rst_n});
				chk("irq", i < 7, ext_irq_n);
			end
			set_act(9'h000);
			chk("idle", 2'h3, {main_poweron_rst_n, ext_irq_n});
		end
		$display("test reset_sources done");
		for (int i = 0; i < 7; i++)
		begin
			@(posedge hclk);
			dip_code <= ctab[i];
			set_act(9'h001);
			set_act(9'h000);
			chk("mode", mtab[i], boot_mode);
			chk("lanes", ltab[i], flash_lanes);
			chk("mhz", ftab[i], flash_clk_mhz);
			chk("ddr_loader", {1'b0, i < 5}, {flash_ddr, secondary_loader});
			ahb(1'b0, OFS_BOOT, 32'h0);
			chk("boot_reg", {17'h0, i < 5, 2'b00, ltab[i], 1'b0, mtab[i], ctab[i]}, rd);
			ahb(1'b0, OFS_FLASH_CLK, 32'h0);
			chk("clk_reg", ftab[i], rd);
			@(posedge hclk);
			dip_code <= ~ctab[i];
			ahb(1'b1, OFS_CTRL, 32'h3);
			wait_cyc(8);
			chk("held", ctab[i], boot_code);
			chk("fallback", (i == 0 || i == 2 || i == 3) ? BOOT_UART : mtab[i], boot_mode);
			if (i == 4)
				chk("xspi", {1'b1, LANES_8}, {flash_ddr, flash_lanes});
		end
		$display("test boot_codes done");
		@(posedge hclk);
		har_drive <= 1'b1;
		har_code <= CODE_XSPI;
		set_act(9'h008);
		set_act(9'h000);
		chk("har_code", CODE_XSPI, boot_code);
		@(posedge hclk);
		har_drive <= 1'b0;
		wait_cyc(10);
		chk("har_held", CODE_XSPI, boot_code);
		$display("test harness_boot done");
		ahb(1'b1, 32'h28, 32'h3);
		ahb(1'b0, OFS_UART_BAUD, 32'h0);
		chk("baud", UART_BAUD, rd);
		chk("resp", 2'h2, {hreadyout, hresp});
		ahb(1'b0, 32'h1C, 32'h0);
		chk("unmapped", 32'h0, rd);
		ahb(1'b0, OFS_STATUS, 32'h0);
		chk("status_por", 1'b1, rd[0]);
		chk("alias_ddr", 5'h01, {flash_ddr, flash_lanes});
		$display("test registers done");
		wait_ref(1'b0);
		wait_ref(1'b1);
		n = 0;
		wait_ref(1'b0);
		wait_ref(1'b1);
		chk("ref_period", CLK_MHZ / REF_MHZ, n);
		@(posedge hclk);
		jtag_sw <= 1'b1;
		wait_cyc(10);
		chk("jtag", 1'b1, jtag_sel);
		$display("test clock_jtag done");
		close_out();
	end
endmodule : tb_top
